// ===== ahc_host_ctl.sv
// io decode and conversion control for the acquisition card
`timescale 1ns/100ps
module ahc_host_ctl
  import ahc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [3:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_rvalid,
  input wire logic dma_ack,
  output logic dma_req,
  output logic irq_req,
  input wire logic trigger_source_strap,
  input wire logic ext_trigger,
  input wire logic pacer_pulse,
  output logic adc_start,
  input wire logic adc_done,
  input wire logic [15:0] adc_data,
  output logic adc_ready,
  input wire logic [15:0] input_port_bits,
  output logic [15:0] output_port_bits,
  output logic [11:0] analog_out1_code,
  output logic [11:0] analog_out2_code,
  output logic timer_sel,
  output logic [1:0] timer_addr,
  output logic timer_wr,
  output logic timer_rd,
  output logic [7:0] timer_wdata,
  input wire logic [7:0] timer_rdata
);
  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  // code assembly, upper nibble dropped
  function automatic logic [11:0] ahc_ao_code(input logic [7:0] hi, input logic [7:0] lo);
    ahc_ao_code = {hi[AHC_AO_HI_BITS-1:0], lo};
  endfunction

  // mode decode, unlisted codes fall to off
  function automatic ahc_mode_t ahc_mode_decode(input logic [2:0] code);
    if (code == AHC_MODE_SOFT) begin
      ahc_mode_decode = AHC_M_SOFT;
    end else if (code == AHC_MODE_DMA) begin
      ahc_mode_decode = AHC_M_DMA;
    end else if (code == AHC_MODE_INT) begin
      ahc_mode_decode = AHC_M_INT;
    end else begin
      ahc_mode_decode = AHC_M_OFF;
    end
  endfunction

  function automatic logic ahc_hit(input logic strobe, input logic [3:0] a,
                                   input logic [3:0] ofs);
    ahc_hit = strobe && (a == ofs);
  endfunction

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  ahc_buf_if rbuf ();
  ahc_mode_t mode;
  logic host_wr;
  logic host_rd;
  logic rd_pend;
  logic rd_dma;
  logic [3:0] rd_addr;
  logic dma_hi;
  logic pacer_prev;
  logic ext_prev;
  logic pacer_edge;
  logic ext_edge;
  logic soft_trig;
  logic start_now;
  logic pend_flag;
  logic irq_flag;
  logic [7:0] ao1_stage;
  logic [7:0] ao2_stage;
  logic res_visible;
  logic rd_res_lo;
  logic pop_now;
  logic [7:0] next_rdata;
  logic is_timer;

  // ---------------------------------------------------------------
  // result buffer
  // ---------------------------------------------------------------
  // a stalled reader backs up into the converter via adc_ready
  ahc_result_buf u_buf (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .bus(rbuf.buffer)
  );

  assign rbuf.in_valid = adc_done;
  assign rbuf.in_data = adc_data;
  assign rbuf.out_ready = pop_now;

  // converter handshake tracks the buffer's ready flag edge for edge; a one-cycle lag
  // would let the converter drop a word the full buffer refused, or offer one twice
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      adc_ready <= 1'b1;
    end else if (adc_done && rbuf.in_ready && !pop_now) begin
      // a push onto one held word fills the buffer
      adc_ready <= !rbuf.out_valid;
    end else if (pop_now && !(adc_done && rbuf.in_ready)) begin
      adc_ready <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // host strobes
  // ---------------------------------------------------------------
  // a dma acknowledge cycle is not a normal register access
  assign host_wr = io_wr && !dma_ack;
  assign host_rd = io_rd && !dma_ack;
  assign is_timer = (io_addr <= AHC_OFS_TCTL);

  // ---------------------------------------------------------------
  // mode register
  // ---------------------------------------------------------------
  // reset value is soft/poll
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode <= AHC_M_SOFT;
    end else if (ahc_hit(host_wr, io_addr, AHC_OFS_MODE)) begin
      // only the low three bits are kept
      mode <= ahc_mode_decode(io_wdata[2:0]);
    end
  end

  // ---------------------------------------------------------------
  // trigger sources
  // ---------------------------------------------------------------
  // previous levels for rising-edge detection of the pin inputs
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pacer_prev <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      pacer_prev <= pacer_pulse;
      ext_prev <= ext_trigger;
    end
  end

  // pacer_pulse is the output of the cascaded counter pair
  assign pacer_edge = pacer_pulse && !pacer_prev;
  assign ext_edge = ext_trigger && !ext_prev;
  // data value ignored, any write triggers
  assign soft_trig = ahc_hit(host_wr, io_addr, AHC_OFS_TRIG);

  // strap high selects the external source only
  always_comb begin
    if (trigger_source_strap) begin
      start_now = ext_edge;
    end else begin
      case (mode)
        AHC_M_SOFT: start_now = soft_trig;
        AHC_M_DMA: start_now = pacer_edge;
        AHC_M_INT: start_now = pacer_edge;
        default: start_now = 1'b0;
      endcase
    end
  end

  // one-cycle start pulse to the converter
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      adc_start <= 1'b0;
    end else begin
      adc_start <= start_now;
    end
  end

  // ---------------------------------------------------------------
  // ready flag
  // ---------------------------------------------------------------
  assign res_visible = rbuf.out_valid && (mode != AHC_M_DMA);
  assign rd_res_lo = rd_pend && !rd_dma && (rd_addr == AHC_OFS_RES_LO);

  // busy from start, cleared when the result is stored
  // a low-byte read sets it again; set wins over the clear
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pend_flag <= 1'b0;
    end else if (adc_start || rd_res_lo) begin
      pend_flag <= 1'b1;
    end else if (adc_done && rbuf.in_ready) begin
      pend_flag <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // interrupt flag
  // ---------------------------------------------------------------
  // raised at conversion end in interrupt mode only
  // sticky until a write to the clear offset; a new event wins
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_flag <= 1'b0;
    end else if (mode == AHC_M_INT && adc_done && rbuf.in_ready) begin
      irq_flag <= 1'b1;
    end else if (ahc_hit(host_wr, io_addr, AHC_OFS_IRQ_CLR)) begin
      irq_flag <= 1'b0;
    end
  end

  // request pin follows the flag, dropped when mode leaves interrupt
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= irq_flag && (mode == AHC_M_INT);
    end
  end

  // ---------------------------------------------------------------
  // dma request
  // ---------------------------------------------------------------
  // request while a word waits; low for a cycle after each word
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dma_req <= 1'b0;
    end else begin
      dma_req <= (mode == AHC_M_DMA) && rbuf.out_valid && !pop_now;
    end
  end

  // byte order within a dma word: low byte first, then high byte
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dma_hi <= 1'b0;
    end else if (mode != AHC_M_DMA) begin
      dma_hi <= 1'b0;
    end else if (rd_pend && rd_dma) begin
      dma_hi <= ~dma_hi;
    end
  end

  // ---------------------------------------------------------------
  // read pipeline
  // ---------------------------------------------------------------
  // stage one captures the access, stage two returns the byte
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_pend <= 1'b0;
      rd_dma <= 1'b0;
      rd_addr <= 4'h0;
    end else begin
      rd_pend <= io_rd;
      rd_dma <= io_rd && dma_ack;
      rd_addr <= io_addr;
    end
  end

  // pop after the high byte, by host poll or by dma
  always_comb begin
    pop_now = 1'b0;
    if (rd_pend && rd_dma) begin
      pop_now = dma_hi && rbuf.out_valid;
    end else if (rd_pend && rd_addr == AHC_OFS_RES_HI) begin
      pop_now = res_visible;
    end
  end

  // read data mux; unmapped and write-only offsets read zero
  always_comb begin
    next_rdata = 8'h00;
    if (rd_dma) begin
      // acknowledged cycle carries the waiting word
      next_rdata = dma_hi ? rbuf.out_data[15:8] : rbuf.out_data[7:0];
    end else if (rd_addr <= AHC_OFS_TCTL) begin
      next_rdata = timer_rdata;
    end else if (rd_addr == AHC_OFS_RES_LO) begin
      // result hidden while dma owns it
      next_rdata = res_visible ? rbuf.out_data[7:0] : 8'h00;
    end else if (rd_addr == AHC_OFS_RES_HI) begin
      next_rdata = res_visible ? rbuf.out_data[15:8] : 8'h00;
    end else if (rd_addr == AHC_OFS_DIN_LO) begin
      next_rdata = input_port_bits[7:0];
    end else if (rd_addr == AHC_OFS_DIN_HI) begin
      next_rdata = input_port_bits[15:8];
    end else if (rd_addr == AHC_OFS_STATUS) begin
      // ready flag in bit 5, not shown in dma mode
      next_rdata[AHC_PEND_BIT] = pend_flag && (mode != AHC_M_DMA);
    end
  end

  // registered read answer, valid for one cycle
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      io_rdata <= 8'h00;
      io_rvalid <= 1'b0;
    end else begin
      io_rvalid <= rd_pend;
      if (rd_pend) begin
        io_rdata <= next_rdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // timer window
  // ---------------------------------------------------------------
  // strobes forwarded one cycle late with address and data
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_sel <= 1'b0;
      timer_addr <= 2'h0;
      timer_wr <= 1'b0;
      timer_rd <= 1'b0;
      timer_wdata <= 8'h00;
    end else begin
      timer_sel <= (host_wr || host_rd) && is_timer;
      timer_wr <= host_wr && is_timer;
      timer_rd <= host_rd && is_timer;
      if ((host_wr || host_rd) && is_timer) begin
        timer_addr <= io_addr[1:0];
        timer_wdata <= io_wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // digital outputs
  // ---------------------------------------------------------------
  // each byte latched by its own offset
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      output_port_bits <= AHC_DOUT_RESET;
    end else if (ahc_hit(host_wr, io_addr, AHC_OFS_DOUT_LO)) begin
      output_port_bits[7:0] <= io_wdata;
    end else if (ahc_hit(host_wr, io_addr, AHC_OFS_DOUT_HI)) begin
      output_port_bits[15:8] <= io_wdata;
    end
  end

  // ---------------------------------------------------------------
  // output converters
  // ---------------------------------------------------------------
  // low byte staged only; reads at these offsets are unaffected
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ao1_stage <= 8'h00;
      ao2_stage <= 8'h00;
    end else if (ahc_hit(host_wr, io_addr, AHC_OFS_AO1_LO)) begin
      ao1_stage <= io_wdata;
    end else if (ahc_hit(host_wr, io_addr, AHC_OFS_AO2_LO)) begin
      ao2_stage <= io_wdata;
    end
  end

  // both bytes move together so the output steps once
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      analog_out1_code <= AHC_AO_RESET;
      analog_out2_code <= AHC_AO_RESET;
    end else if (ahc_hit(host_wr, io_addr, AHC_OFS_AO1_HI)) begin
      analog_out1_code <= ahc_ao_code(io_wdata, ao1_stage);
    end else if (ahc_hit(host_wr, io_addr, AHC_OFS_AO2_HI)) begin
      analog_out2_code <= ahc_ao_code(io_wdata, ao2_stage);
    end
  end
endmodule

// ===== ahc_pkg.sv
// shared constants and types for the acquisition card host control block
package ahc_pkg;
  // ---------------------------------------------------------------
  // io offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] AHC_OFS_CNT0 = 4'h0;
  localparam logic [3:0] AHC_OFS_CNT1 = 4'h1;
  localparam logic [3:0] AHC_OFS_CNT2 = 4'h2;
  localparam logic [3:0] AHC_OFS_TCTL = 4'h3;
  localparam logic [3:0] AHC_OFS_RES_LO = 4'h4;
  localparam logic [3:0] AHC_OFS_RES_HI = 4'h5;
  localparam logic [3:0] AHC_OFS_DIN_LO = 4'h6;
  localparam logic [3:0] AHC_OFS_DIN_HI = 4'h7;
  localparam logic [3:0] AHC_OFS_AO1_LO = 4'h4;
  localparam logic [3:0] AHC_OFS_AO1_HI = 4'h5;
  localparam logic [3:0] AHC_OFS_AO2_LO = 4'h6;
  localparam logic [3:0] AHC_OFS_AO2_HI = 4'h7;
  localparam logic [3:0] AHC_OFS_STATUS = 4'h8;
  localparam logic [3:0] AHC_OFS_IRQ_CLR = 4'h8;
  localparam logic [3:0] AHC_OFS_MODE = 4'hB;
  localparam logic [3:0] AHC_OFS_TRIG = 4'hC;
  localparam logic [3:0] AHC_OFS_DOUT_LO = 4'hD;
  localparam logic [3:0] AHC_OFS_DOUT_HI = 4'hE;
  // ---------------------------------------------------------------
  // field layout and reset values
  // ---------------------------------------------------------------
  localparam int AHC_PEND_BIT = 5;
  localparam int AHC_AO_HI_BITS = 4;
  localparam logic [2:0] AHC_MODE_OFF = 3'h0;
  localparam logic [2:0] AHC_MODE_SOFT = 3'h1;
  localparam logic [2:0] AHC_MODE_DMA = 3'h2;
  localparam logic [2:0] AHC_MODE_INT = 3'h6;
  localparam logic [15:0] AHC_DOUT_RESET = 16'h0000;
  localparam logic [11:0] AHC_AO_RESET = 12'h000;
  localparam int AHC_BUF_WIDTH = 16;
  localparam int AHC_BUF_DEPTH = 2;
  // acquisition modes, one-hot
  typedef enum logic [3:0] {
    AHC_M_OFF = 4'b0001,
    AHC_M_SOFT = 4'b0010,
    AHC_M_DMA = 4'b0100,
    AHC_M_INT = 4'b1000
  } ahc_mode_t;
endpackage

// ===== ahc_buf_if.sv
// valid/ready carrier between the control logic and its result buffer
`timescale 1ns/100ps
interface ahc_buf_if;
  import ahc_pkg::*;
  logic in_valid;
  logic in_ready;
  logic [AHC_BUF_WIDTH-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [AHC_BUF_WIDTH-1:0] out_data;
  modport ctl (output in_valid, input in_ready, output in_data,
               input out_valid, output out_ready, input out_data);
  modport buffer (input in_valid, output in_ready, input in_data,
                  output out_valid, input out_ready, output out_data);
endinterface

// ===== ahc_result_buf.sv
// two-entry result buffer with registered full and empty flags
`timescale 1ns/100ps
module ahc_result_buf
  import ahc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  ahc_buf_if.buffer bus
);
  logic [AHC_BUF_WIDTH-1:0] mem [AHC_BUF_DEPTH];
  logic wptr;
  logic rptr;
  logic [1:0] count;
  logic push;
  logic pop;

  // ---------------------------------------------------------------
  // handshakes
  // ---------------------------------------------------------------
  assign push = bus.in_valid && bus.in_ready;
  assign pop = bus.out_valid && bus.out_ready;
  assign bus.out_data = mem[rptr];

  // storage, written only on an accepted push
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wptr] <= bus.in_data;
    end
  end

  // pointers and fill level; flags are flops so ready never glitches
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wptr <= 1'b0;
      rptr <= 1'b0;
      count <= 2'h0;
      bus.in_ready <= 1'b1;
      bus.out_valid <= 1'b0;
    end else begin
      if (push) begin
        wptr <= ~wptr;
      end
      if (pop) begin
        rptr <= ~rptr;
      end
      if (push && !pop) begin
        count <= count + 2'h1;
        bus.in_ready <= (count != 2'h1);
        bus.out_valid <= 1'b1;
      end else if (pop && !push) begin
        count <= count - 2'h1;
        bus.in_ready <= 1'b1;
        bus.out_valid <= (count != 2'h1);
      end
    end
  end
endmodule

// ===== ahc_host_ctl_props.sv
// port-level timing checker for the acquisition card host control
`timescale 1ns/100ps
module ahc_host_ctl_props
  import ahc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [3:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic io_rvalid,
  input wire logic dma_ack,
  input wire logic dma_req,
  input wire logic irq_req,
  input wire logic trigger_source_strap,
  input wire logic ext_trigger,
  input wire logic pacer_pulse,
  input wire logic adc_start,
  input wire logic adc_done,
  input wire logic [15:0] input_port_bits,
  input wire logic [15:0] output_port_bits,
  input wire logic [11:0] analog_out1_code,
  input wire logic timer_sel,
  input wire logic timer_wr,
  input wire logic [1:0] timer_addr,
  input wire logic [7:0] timer_wdata
);
  // ---------------------------------------------------------------
  // shadow of the write-only mode field
  // ---------------------------------------------------------------
  logic [2:0] mode_q;
  logic bad_q;
  // the field cannot be read back, so the checker keeps its own copy
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_q <= AHC_MODE_SOFT;
    end else if (io_wr && io_addr == AHC_OFS_MODE) begin
      mode_q <= io_wdata[2:0];
    end
  end
  assign bad_q = !(mode_q inside {AHC_MODE_SOFT, AHC_MODE_DMA, AHC_MODE_INT});
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_din_rd;
    io_rd && !dma_ack && io_addr == AHC_OFS_DIN_LO ##1 1'b1;
  endsequence
  sequence s_irq_clr;
    io_wr && io_addr == AHC_OFS_IRQ_CLR && !adc_done ##1 !adc_done;
  endsequence
  a_soft_start: assert property (
    io_wr && io_addr == AHC_OFS_TRIG && !trigger_source_strap && mode_q == AHC_MODE_SOFT
    |=> adc_start) else $error("trigger write gave no start");
  a_ext_only: assert property (
    adc_start && $past(trigger_source_strap) |-> $past(ext_trigger) && !$past(ext_trigger, 2))
    else $error("start without external edge under strap");
  a_pacer_start: assert property (
    !trigger_source_strap && (mode_q == AHC_MODE_DMA || mode_q == AHC_MODE_INT)
    && $rose(pacer_pulse) |=> adc_start) else $error("pacer edge gave no start");
  a_bad_mode_quiet: assert property (
    bad_q && $past(bad_q) && $past(bad_q, 2) && !$past(trigger_source_strap)
    |-> !adc_start && !irq_req && !dma_req) else $error("activity in disabled mode");
  a_dout_latch: assert property (
    io_wr && io_addr == AHC_OFS_DOUT_LO |=> output_port_bits[7:0] == $past(io_wdata))
    else $error("output low byte not latched");
  a_ao_staged: assert property (
    io_wr && io_addr == AHC_OFS_AO1_LO |=> $stable(analog_out1_code))
    else $error("converter code moved on low byte");
  a_ao_high_load: assert property (
    io_wr && io_addr == AHC_OFS_AO1_HI |=> analog_out1_code[11:8] == $past(io_wdata[3:0]))
    else $error("converter high nibble wrong");
  a_timer_fwd: assert property (
    io_wr && io_addr[3:2] == 2'h0 |=> timer_sel && timer_wr
    && timer_addr == $past(io_addr[1:0]) && timer_wdata == $past(io_wdata))
    else $error("timer write not forwarded");
  a_din_read: assert property (
    s_din_rd |=> io_rvalid && io_rdata == $past(input_port_bits[7:0]))
    else $error("input low byte read wrong");
  a_irq_clear: assert property (
    s_irq_clr |=> !irq_req) else $error("interrupt not cleared");
  a_irq_mode: assert property (
    irq_req |-> $past(mode_q) == AHC_MODE_INT) else $error("interrupt outside its mode");
endmodule
bind ahc_host_ctl ahc_host_ctl_props u_props (
  .sys_clk, .sys_rst, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .io_rvalid,
  .dma_ack, .dma_req, .irq_req, .trigger_source_strap, .ext_trigger, .pacer_pulse,
  .adc_start, .adc_done, .input_port_bits, .output_port_bits, .analog_out1_code,
  .timer_sel, .timer_wr, .timer_addr, .timer_wdata
);

// ===== ahc_conv_model.sv
// behavioural converter and timer stand-in on the far side of the control block
`timescale 1ns/100ps
module ahc_conv_model (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic slow,
  input wire logic adc_start,
  input wire logic adc_ready,
  output logic adc_done,
  output logic [15:0] adc_data,
  input wire logic timer_sel,
  input wire logic timer_rd,
  input wire logic [1:0] timer_addr,
  output logic [7:0] timer_rdata
);
  // ---------------------------------------------------------------
  // conversion timing
  // ---------------------------------------------------------------
  logic [4:0] wait_cnt;
  logic [15:0] word;
  // a finished word is held until the control block can take it
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_cnt <= 5'h00;
      adc_done <= 1'b0;
      word <= 16'h8001;
    end else if (adc_done) begin
      if (adc_ready) begin
        adc_done <= 1'b0;
        word <= word + 16'h1111;
      end
    end else if (adc_start) begin
      wait_cnt <= slow ? 5'h0C : 5'h03;
    end else if (wait_cnt == 5'h01) begin
      wait_cnt <= 5'h00;
      adc_done <= 1'b1;
    end else if (wait_cnt != 5'h00) begin
      wait_cnt <= wait_cnt - 5'h01;
    end
  end
  // outside a valid window the lines carry garbage so stale values never pass
  assign adc_data = adc_done ? word : ~word;
  assign timer_rdata = (timer_sel && timer_rd) ? {6'h2A, timer_addr} : ~{6'h2A, timer_addr};
endmodule

// ===== tb.sv
// self-checking bench for the acquisition card host control
`timescale 1ns/100ps
module tb;
  import ahc_pkg::*;
  logic sys_clk = 1'b0, sys_rst = 1'b1, io_wr = 1'b0, io_rd = 1'b0, dma_ack = 1'b0;
  logic trigger_source_strap = 1'b0, ext_trigger = 1'b0, pacer_pulse = 1'b0, slow = 1'b0;
  logic [3:0] io_addr = 4'h0;
  logic [7:0] io_wdata = 8'h00;
  logic [15:0] input_port_bits = 16'hA55A;
  logic io_rvalid, dma_req, irq_req, adc_start, adc_done, adc_ready;
  logic timer_sel, timer_wr, timer_rd;
  logic [15:0] adc_data, output_port_bits, exp_word = 16'h8001;
  logic [11:0] analog_out1_code, analog_out2_code;
  logic [1:0] timer_addr;
  logic [7:0] io_rdata, timer_wdata, timer_rdata, rdv;
  int error_cnt = 0, cmp_count = 0, start_cnt = 0, cyc = 0, n0;
  ahc_host_ctl DUT (.sys_clk, .sys_rst, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata,
    .io_rvalid, .dma_ack, .dma_req, .irq_req, .trigger_source_strap, .ext_trigger,
    .pacer_pulse, .adc_start, .adc_done, .adc_data, .adc_ready, .input_port_bits,
    .output_port_bits, .analog_out1_code, .analog_out2_code, .timer_sel, .timer_addr,
    .timer_wr, .timer_rd, .timer_wdata, .timer_rdata);
  ahc_conv_model u_conv (.sys_clk, .sys_rst, .slow, .adc_start, .adc_ready, .adc_done,
    .adc_data, .timer_sel, .timer_rd, .timer_addr, .timer_rdata);
  // ---------------------------------------------------------------
  // clock, start counter and hang guard
  // ---------------------------------------------------------------
  always #2.5 sys_clk = ~sys_clk;
  // the whole run needs about three hundred cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (adc_start === 1'b1) start_cnt++;
    if (cyc == 5000) begin
      error_cnt++;
      end_sim();
    end
  end
  // ---------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask
  task automatic end_sim();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // strobes drop one cycle before the next access so no signal is set twice at once
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(posedge sys_clk);
    #1 io_wr = 1'b0;
    idle(1);
  endtask
  task automatic rd(input logic [3:0] a);
    io_addr = a;
    io_rd = 1'b1;
    @(posedge sys_clk);
    #1 io_rd = 1'b0;
    idle(1);
    chk("read valid", io_rvalid, 1'b1);
    rdv = io_rdata;
  endtask
  task automatic drain();
    rd(AHC_OFS_RES_LO);
    chk("result low", rdv, exp_word[7:0]);
    rd(AHC_OFS_STATUS);
    chk("flag after low read", rdv[AHC_PEND_BIT], 1'b1);
    rd(AHC_OFS_RES_HI);
    chk("result high", rdv, exp_word[15:8]);
    exp_word += 16'h1111;
  endtask
  // host side of a transfer cycle pair; the address is ignored while acknowledged
  task automatic dma_pair();
    dma_ack = 1'b1;
    rd(4'hF);
    chk("transfer low", rdv, exp_word[7:0]);
    rd(4'hF);
    chk("transfer high", rdv, exp_word[15:8]);
    dma_ack = 1'b0;
    exp_word += 16'h1111;
  endtask
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    idle(10);
    sys_rst = 1'b0;
    slow = 1'b1;
    wr(AHC_OFS_TRIG, 8'h00);
    rd(AHC_OFS_STATUS);
    chk("busy flag", rdv[AHC_PEND_BIT], 1'b1);
    idle(20);
    rd(AHC_OFS_STATUS);
    chk("done flag", rdv[AHC_PEND_BIT], 1'b0);
    drain();
    slow = 1'b0;
    rd(AHC_OFS_DIN_LO);
    chk("input low", rdv, 8'h5A);
    rd(AHC_OFS_DIN_HI);
    chk("input high", rdv, 8'hA5);
    wr(AHC_OFS_DOUT_LO, 8'h3C);
    wr(AHC_OFS_DOUT_HI, 8'hC3);
    chk("outputs", output_port_bits, 16'hC33C);
    wr(AHC_OFS_AO1_LO, 8'h12);
    chk("ao1 staged", analog_out1_code, 12'h000);
    wr(AHC_OFS_AO1_HI, 8'hF7);
    chk("ao1 code", analog_out1_code, 12'h712);
    wr(AHC_OFS_AO2_LO, 8'h34);
    wr(AHC_OFS_AO2_HI, 8'hA9);
    chk("ao2 code", analog_out2_code, 12'h934);
    wr(AHC_OFS_TCTL, 8'h76);
    rd(AHC_OFS_CNT1);
    chk("timer read", rdv, 8'hA9);
    rd(4'hF);
    chk("unmapped read", rdv, 8'h00);
    rd(AHC_OFS_MODE);
    chk("mode read", rdv, 8'h00);
    // every mode code, with junk in the ignored upper bits
    for (int m = 0; m < 8; m++) begin
      wr(AHC_OFS_MODE, {5'h1F, 3'(m)});
      n0 = start_cnt;
      wr(AHC_OFS_TRIG, 8'hFF);
      pacer_pulse = 1'b1;
      idle(2);
      pacer_pulse = 1'b0;
      idle(10);
      chk("starts", 16'(start_cnt - n0), 16'(m == 1 || m == 2 || m == 6));
      chk("irq", irq_req, m == 6);
      chk("dma request", dma_req, m == 2);
      if (m == 2) begin
        rd(AHC_OFS_RES_LO);
        chk("poll in dma", rdv, 8'h00);
        dma_pair();
        idle(2);
        chk("dma dropped", dma_req, 1'b0);
      end else if (m == 1 || m == 6) begin
        drain();
      end
      wr(AHC_OFS_IRQ_CLR, 8'h00);
      idle(1);
      chk("irq cleared", irq_req, 1'b0);
    end
    // receiver stalls: three words against a two-entry buffer
    wr(AHC_OFS_MODE, 8'h01);
    repeat (3) begin
      wr(AHC_OFS_TRIG, 8'h00);
      idle(8);
    end
    chk("buffer full", adc_ready, 1'b0);
    repeat (3) drain();
    chk("buffer empty", adc_ready, 1'b1);
    // external strap shuts out both internal sources
    trigger_source_strap = 1'b1;
    n0 = start_cnt;
    wr(AHC_OFS_TRIG, 8'h00);
    wr(AHC_OFS_MODE, 8'h02);
    pacer_pulse = 1'b1;
    idle(2);
    pacer_pulse = 1'b0;
    ext_trigger = 1'b1;
    idle(2);
    ext_trigger = 1'b0;
    idle(10);
    chk("external starts", 16'(start_cnt - n0), 16'h0001);
    dma_pair();
    end_sim();
  end
endmodule
